// ---- mct_pkg.sv ----
package mct_pkg;

  // ==========================================================
  // Bus geometry
  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 32;
  localparam int STRB_W    = DATA_W / 8;
  localparam int WORD_LSB  = 2;
  localparam int MATCH_LSB = 4;

  // ==========================================================
  // Register offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_COUNT    = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_PRESCALE = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_PCOUNT   = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_MCTL     = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_CAPC     = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_CAPTURE  = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_FLAGS    = 8'h1c;
  localparam logic [ADDR_W-1:0] OFF_EXT      = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_MATCH0   = 8'h30;

  // ==========================================================
  // Field layouts
  localparam int NUM_MATCH   = 4;
  localparam int CTRL_W      = 5;
  localparam int CTRL_EN     = 0;
  localparam int CTRL_RST    = 1;
  localparam int CTRL_MODE   = 2;
  localparam int CTRL_RISE   = 3;
  localparam int CTRL_FALL   = 4;
  localparam int MCTL_STRIDE = 3;
  localparam int MCTL_W      = NUM_MATCH * MCTL_STRIDE;
  localparam int MCTL_INT    = 0;
  localparam int MCTL_RST    = 1;
  localparam int MCTL_STOP   = 2;
  localparam int CAPC_W      = 3;
  localparam int CAPC_RISE   = 0;
  localparam int CAPC_FALL   = 1;
  localparam int CAPC_INT    = 2;
  localparam int FLAG_W      = NUM_MATCH + 1;
  localparam int FLAG_CAP    = NUM_MATCH;
  localparam int ACT_W       = 2;
  localparam int EXT_ACT_LSB = NUM_MATCH;
  localparam int EXT_W       = NUM_MATCH + NUM_MATCH * ACT_W;

  // ==========================================================
  // Match output actions and bus responses
  localparam logic [ACT_W-1:0] ACT_NONE   = 2'h0;
  localparam logic [ACT_W-1:0] ACT_LOW    = 2'h1;
  localparam logic [ACT_W-1:0] ACT_HIGH   = 2'h2;
  localparam logic [ACT_W-1:0] ACT_TOGGLE = 2'h3;
  localparam logic [1:0]       RESP_OKAY   = 2'h0;
  localparam logic [1:0]       RESP_SLVERR = 2'h2;

endpackage

// ---- mct_edge.sv ----
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// Edge detector for a synchronous input
module mct_edge (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Level in, pulses out
  input  wire logic sig_in,
  output logic      rise,
  output logic      fall
);

  logic prev_q;

  // Previous level resets low, so a high input counts as a rise
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= sig_in;
    end
  end

  assign rise = sig_in & ~prev_q;
  assign fall = ~sig_in & prev_q;

endmodule

`default_nettype wire

// ---- mct_timer.sv ----
// The address map and the AXI4-Lite register port were decided locally.
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - In timer mode the count advances from cycles of the system clock.
// - The counter width is a parameter, 32 bits by default.
// - A prescaler as wide as the counter divides the count clock before the main counter.
// - A mode bit selects timer counting or counting of edges on the count input.
// - Four match values are compared with the running count.
// - A match may let the count run on, optionally raising an interrupt flag.
// - A match may stop the count at the match value, optionally raising a flag.
// - A match may clear the count to zero, optionally raising a flag, for periodic use.
// - One capture channel copies the count into a holding register on an input transition.
// - When enabled, a capture also raises an interrupt flag.
// - Four match outputs go low, go high, toggle or stay on their match.
// - All flags are ORed onto one interrupt line and stay readable one by one.
module mct_timer
  import mct_pkg::*;
#(
  parameter int CNT_W = 32
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write channels
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [STRB_W-1:0] wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // AXI4-Lite read channels
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [DATA_W-1:0]      rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Pins
  input  wire logic              count_in,
  input  wire logic              cap_in,
  output logic [NUM_MATCH-1:0]   match_out,
  output logic                   irq
);

  // ==========================================================
  // Decode helpers
  function automatic logic at(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    return a[ADDR_W-1:WORD_LSB] == off[ADDR_W-1:WORD_LSB];
  endfunction

  function automatic logic is_match(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:MATCH_LSB] == OFF_MATCH0[ADDR_W-1:MATCH_LSB];
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return at(a, OFF_CTRL) | at(a, OFF_COUNT) | at(a, OFF_PRESCALE) | at(a, OFF_PCOUNT)
         | at(a, OFF_MCTL) | at(a, OFF_CAPC) | at(a, OFF_CAPTURE) | at(a, OFF_FLAGS)
         | at(a, OFF_EXT) | is_match(a);
  endfunction

  function automatic logic [DATA_W-1:0] wmerge(input logic [DATA_W-1:0] old,
                                               input logic [DATA_W-1:0] nw,
                                               input logic [STRB_W-1:0] strb);
    logic [DATA_W-1:0] r;
    r = old;
    for (int b = 0; b < STRB_W; b++) begin
      if (strb[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    end
    return r;
  endfunction

  function automatic logic act_out(input logic [ACT_W-1:0] code, input logic cur);
    case (code)
      ACT_LOW:    return 1'b0;
      ACT_HIGH:   return 1'b1;
      ACT_TOGGLE: return ~cur;
      default:    return cur;
    endcase
  endfunction

  // ==========================================================
  // Bus slave
  logic                  aw_held_q, w_held_q, bvalid_q, rvalid_q;
  logic [ADDR_W-1:0]     waddr_q;
  logic [DATA_W-1:0]     wdata_q, rdata_q, rd_word;
  logic [STRB_W-1:0]     wstrb_q;
  logic [1:0]            bresp_q, rresp_q;
  logic                  do_wr, rd_take;
  logic [DATA_W-1:0]     wr_mask;

  assign awready = ~aw_held_q;
  assign wready  = ~w_held_q;
  assign arready = ~rvalid_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign rvalid  = rvalid_q;
  assign rdata   = rdata_q;
  assign rresp   = rresp_q;
  assign do_wr   = aw_held_q & w_held_q & ~bvalid_q;
  assign rd_take = arvalid & ~rvalid_q;
  assign wr_mask = wmerge('0, wdata_q, wstrb_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      rvalid_q  <= 1'b0;
      rresp_q   <= RESP_OKAY;
      rdata_q   <= '0;
      waddr_q   <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
    end else begin
      if (awvalid && !aw_held_q) begin
        aw_held_q <= 1'b1;
        waddr_q   <= awaddr;
      end
      if (wvalid && !w_held_q) begin
        w_held_q <= 1'b1;
        wdata_q  <= wdata;
        wstrb_q  <= wstrb;
      end
      if (do_wr) begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= mapped(waddr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid_q <= 1'b0;
      end
      if (rd_take) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_word;
        rresp_q  <= mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Register state
  logic [CTRL_W-1:0]    ctrl_q, ctrl_d;
  logic [CNT_W-1:0]     tc_q, tc_d, pc_q, pc_d, pr_q, pr_d, cr_q, cr_d;
  logic [CNT_W-1:0]     mr_q [NUM_MATCH];
  logic [CNT_W-1:0]     mr_d [NUM_MATCH];
  logic [MCTL_W-1:0]    mctl_q, mctl_d;
  logic [CAPC_W-1:0]    capc_q, capc_d;
  logic [FLAG_W-1:0]    flag_q, flag_d, flag_set, flag_clr;
  logic [EXT_W-1:0]     ext_q, ext_d;

  logic wr_ctrl, wr_tc, wr_pr, wr_pc, wr_mctl, wr_capc, wr_flag, wr_ext, wr_mr;
  logic [MATCH_LSB-WORD_LSB-1:0] widx, ridx;

  assign wr_ctrl = do_wr & at(waddr_q, OFF_CTRL);
  assign wr_tc   = do_wr & at(waddr_q, OFF_COUNT);
  assign wr_pr   = do_wr & at(waddr_q, OFF_PRESCALE);
  assign wr_pc   = do_wr & at(waddr_q, OFF_PCOUNT);
  assign wr_mctl = do_wr & at(waddr_q, OFF_MCTL);
  assign wr_capc = do_wr & at(waddr_q, OFF_CAPC);
  assign wr_flag = do_wr & at(waddr_q, OFF_FLAGS);
  assign wr_ext  = do_wr & at(waddr_q, OFF_EXT);
  assign wr_mr   = do_wr & is_match(waddr_q);
  assign widx    = waddr_q[MATCH_LSB-1:WORD_LSB];
  assign ridx    = araddr[MATCH_LSB-1:WORD_LSB];

  // ==========================================================
  // Counting path
  logic cnt_rise, cnt_fall, cap_rise, cap_fall;
  logic cnt_edge, tick, pc_wrap, crst, any_rst, any_stop, cap_ev;
  logic [NUM_MATCH-1:0] hit, int_en, rst_en, stop_en, tog;

  mct_edge u_cnt_edge (
    .aclk    (aclk),
    .aresetn (aresetn),
    .sig_in  (count_in),
    .rise    (cnt_rise),
    .fall    (cnt_fall)
  );

  mct_edge u_cap_edge (
    .aclk    (aclk),
    .aresetn (aresetn),
    .sig_in  (cap_in),
    .rise    (cap_rise),
    .fall    (cap_fall)
  );

  assign crst     = ctrl_q[CTRL_RST];
  assign cnt_edge = (ctrl_q[CTRL_RISE] & cnt_rise) | (ctrl_q[CTRL_FALL] & cnt_fall);
  assign tick     = ctrl_q[CTRL_EN] & ~crst & (ctrl_q[CTRL_MODE] ? cnt_edge : 1'b1);
  assign pc_wrap  = tick & (pc_q == pr_q);
  assign cap_ev   = (capc_q[CAPC_RISE] & cap_rise) | (capc_q[CAPC_FALL] & cap_fall);

  for (genvar g = 0; g < NUM_MATCH; g++) begin : g_match
    assign hit[g]     = pc_wrap & (tc_q == mr_q[g]);
    assign int_en[g]  = mctl_q[g*MCTL_STRIDE + MCTL_INT];
    assign rst_en[g]  = mctl_q[g*MCTL_STRIDE + MCTL_RST];
    assign stop_en[g] = mctl_q[g*MCTL_STRIDE + MCTL_STOP];
    assign tog[g]     = hit[g] & (ext_q[EXT_ACT_LSB + g*ACT_W +: ACT_W] == ACT_TOGGLE);
  end

  // Reset beats stop on the count when both are armed on one match; stop still clears the enable
  assign any_rst  = |(hit & rst_en);
  assign any_stop = |(hit & stop_en);
  assign flag_set = {cap_ev & capc_q[CAPC_INT], hit & int_en};
  assign flag_clr = wr_flag ? FLAG_W'(wr_mask) : '0;

  always_comb begin
    ctrl_d = ctrl_q;
    tc_d   = tc_q;
    pc_d   = pc_q;
    pr_d   = pr_q;
    cr_d   = cr_q;
    mctl_d = mctl_q;
    capc_d = capc_q;
    ext_d  = ext_q;
    mr_d   = mr_q;
    if (wr_ctrl) ctrl_d = CTRL_W'(wmerge(DATA_W'(ctrl_q), wdata_q, wstrb_q));
    else if (any_stop) ctrl_d[CTRL_EN] = 1'b0;
    if (wr_tc) tc_d = CNT_W'(wmerge(DATA_W'(tc_q), wdata_q, wstrb_q));
    else if (crst || any_rst) tc_d = '0;
    else if (pc_wrap && !any_stop) tc_d = tc_q + CNT_W'(1);
    if (wr_pc) pc_d = CNT_W'(wmerge(DATA_W'(pc_q), wdata_q, wstrb_q));
    else if (crst || pc_wrap) pc_d = '0;
    else if (tick) pc_d = pc_q + CNT_W'(1);
    if (wr_pr) pr_d = CNT_W'(wmerge(DATA_W'(pr_q), wdata_q, wstrb_q));
    if (wr_mctl) mctl_d = MCTL_W'(wmerge(DATA_W'(mctl_q), wdata_q, wstrb_q));
    if (wr_capc) capc_d = CAPC_W'(wmerge(DATA_W'(capc_q), wdata_q, wstrb_q));
    if (cap_ev) cr_d = tc_q;
    if (wr_ext) ext_d = EXT_W'(wmerge(DATA_W'(ext_q), wdata_q, wstrb_q));
    // A match landing with a software write still acts on the pin
    for (int i = 0; i < NUM_MATCH; i++) begin
      if (wr_mr && widx == i[MATCH_LSB-WORD_LSB-1:0]) begin
        mr_d[i] = CNT_W'(wmerge(DATA_W'(mr_q[i]), wdata_q, wstrb_q));
      end
      if (hit[i]) ext_d[i] = act_out(ext_q[EXT_ACT_LSB + i*ACT_W +: ACT_W], ext_q[i]);
    end
  end

  // Set wins over a clear landing in the same cycle
  assign flag_d = (flag_q & ~flag_clr) | flag_set;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= '0;
      tc_q   <= '0;
      pc_q   <= '0;
      pr_q   <= '0;
      cr_q   <= '0;
      mctl_q <= '0;
      capc_q <= '0;
      flag_q <= '0;
      ext_q  <= '0;
      mr_q   <= '{default: '0};
    end else begin
      ctrl_q <= ctrl_d;
      tc_q   <= tc_d;
      pc_q   <= pc_d;
      pr_q   <= pr_d;
      cr_q   <= cr_d;
      mctl_q <= mctl_d;
      capc_q <= capc_d;
      flag_q <= flag_d;
      ext_q  <= ext_d;
      mr_q   <= mr_d;
    end
  end

  assign match_out = ext_q[NUM_MATCH-1:0];
  assign irq       = |flag_q;

  // ==========================================================
  // Read decode
  always_comb begin
    if (at(araddr, OFF_CTRL)) rd_word = DATA_W'(ctrl_q);
    else if (at(araddr, OFF_COUNT)) rd_word = DATA_W'(tc_q);
    else if (at(araddr, OFF_PRESCALE)) rd_word = DATA_W'(pr_q);
    else if (at(araddr, OFF_PCOUNT)) rd_word = DATA_W'(pc_q);
    else if (at(araddr, OFF_MCTL)) rd_word = DATA_W'(mctl_q);
    else if (at(araddr, OFF_CAPC)) rd_word = DATA_W'(capc_q);
    else if (at(araddr, OFF_CAPTURE)) rd_word = DATA_W'(cr_q);
    else if (at(araddr, OFF_FLAGS)) rd_word = DATA_W'(flag_q);
    else if (at(araddr, OFF_EXT)) rd_word = DATA_W'(ext_q);
    else if (is_match(araddr)) rd_word = DATA_W'(mr_q[ridx]);
    else rd_word = '0;
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_timer_tick;
    ctrl_q[CTRL_EN] && !crst && !ctrl_q[CTRL_MODE] && pc_q != pr_q && !wr_pc
      |=> pc_q == CNT_W'($past(pc_q) + CNT_W'(1));
  endproperty
  a_timer_tick: assert property (p_timer_tick) else $error("prescale missed a clock");

  property p_wrap;
    pc_wrap && !wr_pc |=> pc_q == '0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("prescale did not wrap");

  property p_advance;
    pc_wrap && !any_rst && !any_stop && !wr_tc |=> tc_q == CNT_W'($past(tc_q) + CNT_W'(1));
  endproperty
  a_advance: assert property (p_advance) else $error("count did not advance");

  property p_ext_idle;
    ctrl_q[CTRL_MODE] && !cnt_rise && !cnt_fall && !wr_pc && !wr_tc && !crst
      |=> pc_q == $past(pc_q) && tc_q == $past(tc_q);
  endproperty
  a_ext_idle: assert property (p_ext_idle) else $error("counted without an edge");

  property p_stop;
    any_stop && !any_rst && !wr_ctrl && !wr_tc |=> !ctrl_q[CTRL_EN] && tc_q == $past(tc_q);
  endproperty
  a_stop: assert property (p_stop) else $error("stop on match failed");

  property p_reset;
    any_rst && !wr_tc |=> tc_q == '0;
  endproperty
  a_reset: assert property (p_reset) else $error("reset on match failed");

  property p_capture;
    cap_ev |=> cr_q == $past(tc_q);
  endproperty
  a_capture: assert property (p_capture) else $error("capture value wrong");

  property p_cap_flag;
    cap_ev && capc_q[CAPC_INT] |=> flag_q[FLAG_CAP] && irq;
  endproperty
  a_cap_flag: assert property (p_cap_flag) else $error("capture flag missing");

  property p_match_flag;
    |(hit & int_en) |=> (flag_q[NUM_MATCH-1:0] & $past(hit & int_en)) == $past(hit & int_en);
  endproperty
  a_match_flag: assert property (p_match_flag) else $error("match flag missing");

  property p_sticky;
    !wr_flag |=> (flag_q & $past(flag_q)) == $past(flag_q);
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped without write");

  property p_toggle;
    |tog |=> ((match_out ^ $past(match_out)) & $past(tog)) == $past(tog);
  endproperty
  a_toggle: assert property (p_toggle) else $error("match output did not toggle");

  c_periodic: cover property (any_rst ##1 tc_q == '0);
  c_capture:  cover property (cap_ev && capc_q[CAPC_INT]);
  c_stop:     cover property (any_stop ##1 !ctrl_q[CTRL_EN]);

endmodule

`default_nettype wire

// ---- mct_pins.sv ----
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// Pin-side model: count and capture inputs
module mct_pins #(
  parameter int HOLD = 2
) (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Commands from the bench
  input  wire logic       cnt_go,
  input  wire logic [3:0] cnt_num,
  input  wire logic       cap_lvl,
  // Pins
  output logic            count_in,
  output logic            cap_in,
  output logic            busy
);
  logic [4:0] half_q;
  logic [3:0] div_q;

  assign busy = (half_q != 5'h00);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // Pins idle low until the unit is set up
      half_q   <= 5'h00;
      div_q    <= 4'h0;
      count_in <= 1'b0;
      cap_in   <= 1'b0;
    end else begin
      cap_in <= cap_lvl;
      if (cnt_go) begin
        half_q <= {cnt_num, 1'b0};
        div_q  <= 4'h0;
      end else if (busy) begin
        // Slow edges: each level stands HOLD cycles
        if (div_q == 4'(HOLD - 1)) begin
          div_q    <= 4'h0;
          half_q   <= half_q - 5'h01;
          count_in <= ~count_in;
        end else begin
          div_q <= div_q + 4'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- mct_timer_tb.sv ----
`timescale 1ns/100ps
`default_nettype none

module mct_timer_tb
  import mct_pkg::*;
;
  logic                 aclk = 1'b0;
  logic                 aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic                 arvalid, arready, rvalid, rready, count_in, cap_in, irq;
  logic                 cnt_go, cap_lvl, pin_busy;
  logic [ADDR_W-1:0]    awaddr, araddr;
  logic [DATA_W-1:0]    wdata, rdata;
  logic [STRB_W-1:0]    wstrb;
  logic [1:0]           bresp, rresp;
  logic [NUM_MATCH-1:0] match_out;
  logic [3:0]           cnt_num;
  int                   error_cnt, cmp_count, n, i;

  mct_timer mct_timer_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .count_in(count_in), .cap_in(cap_in), .match_out(match_out), .irq(irq));

  mct_pins mct_pins_inst (.aclk(aclk), .aresetn(aresetn), .cnt_go(cnt_go),
    .cnt_num(cnt_num), .cap_lvl(cap_lvl), .count_in(count_in), .cap_in(cap_in),
    .busy(pin_busy));

  always #50 aclk = ~aclk;

  // ==========================================================
  // Checks and bus tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int k;
    logic done;
    k = 0;
    done = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      k++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        chk("bresp", {30'h0, er}, {30'h0, bresp});
        bready <= 1'b0;
        done = 1'b1;
      end else if (k > 50) begin
        chk("bvalid", 32'h1, 32'h0);
        done = 1'b1;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int k;
    logic done;
    k = 0;
    done = 1'b0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      k++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        chk($sformatf("rdata@%h", a), ed, rdata);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
        rready <= 1'b0;
        done = 1'b1;
      end else if (k > 50) begin
        chk("rvalid", 32'h1, 32'h0);
        done = 1'b1;
      end
    end
  endtask

  task automatic wait_irq;
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 200) begin
      @(posedge aclk);
      k++;
    end
    chk("irq", 32'h1, {31'h0, irq});
  endtask

  task automatic wait_chg(output int c);
    logic [3:0] p;
    p = match_out;
    c = 0;
    while (match_out === p && c < 100) begin
      @(posedge aclk);
      c++;
    end
    chk("match_out change", 32'h1, {31'h0, match_out !== p});
  endtask

  task automatic pulses(input logic [3:0] num);
    int k;
    k = 0;
    cnt_num <= num;
    cnt_go  <= 1'b1;
    @(posedge aclk);
    cnt_go <= 1'b0;
    @(posedge aclk);
    while (pin_busy === 1'b1 && k < 100) begin
      @(posedge aclk);
      k++;
    end
    chk("pin_busy", 32'h0, {31'h0, pin_busy});
  endtask

  task automatic stop_test;
    $display("Comparisons %0d, errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // Watchdog: whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge aclk);
    error_cnt++;
    stop_test();
  end

  // ==========================================================
  // Main sequence
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, cnt_go, cap_lvl} = 7'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    cnt_num = 4'h0;
    error_cnt = 0;
    cmp_count = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    chk("irq", 32'h0, {31'h0, irq}); // Quiet line
    chk("match_out", 32'h0, {28'h0, match_out}); // Idle pins
    rd(OFF_CTRL, 32'h0, RESP_OKAY); // Stopped
    rd(OFF_FLAGS, 32'h0, RESP_OKAY); // No flags
    rd(8'h24, 32'h0, RESP_SLVERR); // Hole read
    wr(8'h40, 32'hffff, RESP_SLVERR); // Hole write
    // Stop on match with flag, prescale 1
    wr(OFF_PRESCALE, 32'h1, RESP_OKAY); // Divider
    wr(OFF_MATCH0, 32'h5, RESP_OKAY); // Match value
    wr(OFF_MCTL, 32'h5, RESP_OKAY); // Int and stop
    wr(OFF_CTRL, 32'h1, RESP_OKAY); // Timer run
    wait_irq(); // Flag on match
    rd(OFF_COUNT, 32'h5, RESP_OKAY); // Held at match
    rd(OFF_CTRL, 32'h0, RESP_OKAY); // Enable cleared
    rd(OFF_FLAGS, 32'h1, RESP_OKAY); // Readable flag
    wr(OFF_FLAGS, 32'h1e, RESP_OKAY); // Zero at own bit
    rd(OFF_FLAGS, 32'h1, RESP_OKAY); // Still set
    wr(OFF_FLAGS, 32'h1, RESP_OKAY); // Clear it
    rd(OFF_FLAGS, 32'h0, RESP_OKAY); // Cleared
    chk("irq", 32'h0, {31'h0, irq}); // Line drops
    // Periodic reset, every pin action code
    for (i = 0; i < NUM_MATCH; i++) begin
      wr(OFF_MATCH0 + 8'(4 * i), 32'h2, RESP_OKAY); // All at two
    end
    wr(OFF_COUNT, 32'h0, RESP_OKAY); // Restart
    wr(OFF_MCTL, 32'h00a, RESP_OKAY); // M0 reset, M1 int
    wr(OFF_EXT, 32'h399, RESP_OKAY); // Low, high, toggle, none
    wr(OFF_CTRL, 32'h1, RESP_OKAY); // Run
    wait_chg(n);
    chk("match_out", 32'he, {28'h0, match_out}); // First match
    wait_chg(n);
    chk("match_out", 32'ha, {28'h0, match_out}); // Toggle only
    chk("period", 32'd6, 32'(n)); // (1+1)*(2+1)
    wr(OFF_CTRL, 32'h0, RESP_OKAY); // Halt
    rd(OFF_FLAGS, 32'h2, RESP_OKAY); // Running flag only
    wr(OFF_FLAGS, 32'h1f, RESP_OKAY); // Clear all
    // Capture on rising input, stopped count
    wr(OFF_COUNT, 32'hffffffff, RESP_OKAY); // Full width
    rd(OFF_COUNT, 32'hffffffff, RESP_OKAY); // All bits held
    wr(OFF_COUNT, 32'h1234, RESP_OKAY); // Known count
    wr(OFF_CAPC, 32'h5, RESP_OKAY); // Rise with int
    cap_lvl <= 1'b1;
    wait_irq(); // Capture flag
    rd(OFF_CAPTURE, 32'h1234, RESP_OKAY); // Snapshot
    rd(OFF_FLAGS, 32'h10, RESP_OKAY); // Capture bit
    wr(OFF_CAPTURE, 32'h0, RESP_OKAY); // Read-only
    wr(OFF_FLAGS, 32'h10, RESP_OKAY); // Clear
    cap_lvl <= 1'b0;
    rd(OFF_CAPTURE, 32'h1234, RESP_OKAY); // Write ignored
    rd(OFF_FLAGS, 32'h0, RESP_OKAY); // Fall not armed
    // Event counting on count_in
    wr(OFF_MCTL, 32'h0, RESP_OKAY); // No match int, reset or stop
    wr(OFF_PRESCALE, 32'h0, RESP_OKAY); // No division
    wr(OFF_COUNT, 32'h0, RESP_OKAY); // Start at zero
    wr(OFF_CTRL, 32'hd, RESP_OKAY); // Counter, rising
    pulses(4'h3);
    rd(OFF_COUNT, 32'h3, RESP_OKAY); // Three rises
    wr(OFF_CTRL, 32'h1d, RESP_OKAY); // Both edges
    pulses(4'h2);
    rd(OFF_COUNT, 32'h7, RESP_OKAY); // Four more edges
    stop_test();
  end
endmodule
`default_nettype wire
